// ### logic/linrm_core.sv
/*
 Link controller register set with error detection, reached over
 AHB-Lite (register index times four is the byte address).
 Assumes a frame engine on the same clock that reports header, data,
 checksum and bit timing events, and a transceiver on linRxPin.
*/
// Contract
// - Master-only and slave-only bits obey mode.
// - Error register at 0x0A, read-only, reset zero.
// - Error bits 7:5 read zero, writes ignored.
// - Slave sync field tolerance error sets bit 4.
// - Slave parity error sets bit 3.
// - Master sees no slave response: timeout.
// - Slave expects data, none comes: timeout.
// - Frame longer than maximum length: timeout.
// - No acknowledge or stop by first byte: timeout.
// - Wrong checksum sets bit 1.
// - Monitored bit differs from sent: bit 0.
// - Any error aborts frame and requests interrupt.
// - Clear-errors bit wipes error register and summary.
// - No start or wake-up while summary set.
`timescale 1ns/1ps
module linrm_core #(
    parameter int FRAME_MAX_US = linrm_pkg::FRAME_MAX_US
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic linRxPin,
    input wire logic frameStart,
    input wire logic frameEnd,
    input wire logic idValid,
    input wire logic [7:0] idByte,
    input wire logic rxByteValid,
    input wire logic [2:0] rxByteIdx,
    input wire logic [7:0] rxByte,
    input wire logic chkValid,
    input wire logic [7:0] chkByte,
    input wire logic syncTolFail,
    input wire logic masterNoRespEv,
    input wire logic slaveNoDataEv,
    input wire logic txActive,
    input wire logic txBit,
    input wire logic bitSample,
    input wire logic busActive,
    input wire logic dataReqLvl,
    input wire logic idleTimeoutEv,
    input wire logic wakeupEv,
    input wire logic doneEv,
    output logic [63:0] dataBuf,
    output logic masterMode,
    output logic stopReq,
    output logic sleepMode,
    output logic directionSelect,
    output logic dataAck,
    output logic startRequest,
    output logic wakeupRequest,
    output logic frameAbort,
    output logic enhancedChecksum,
    output logic [3:0] frameLength,
    output logic [7:0] dividerLow,
    output logic [7:0] baudMultiplier,
    output logic [5:0] frameIdentifier,
    output logic irq
);
    localparam int FRAME_MAX_CYC = FRAME_MAX_US * 1000 / linrm_pkg::CLK_NS;

    function automatic logic [7:0] addCarry(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

    // Bus address phase and deferred write data phase
    logic [4:0] addrQ;
    logic wrHitQ;
    logic wrPendQ;
    logic [7:0] rdByte;
    wire accept = hsel && htrans[1] && hready;
    wire [4:0] idx = haddr[6:2];
    wire hit = (haddr[31:7] == 25'h0) && (idx < 5'(linrm_pkg::NUM_REGS));
    wire rdAcc = accept && !hwrite;
    wire wrEn = wrPendQ && wrHitQ;
    wire [7:0] wData = hwdata[7:0];
    wire wrCtrl = wrEn && (addrQ == linrm_pkg::IDX_CTRL);
    wire wrSize = wrEn && (addrQ == linrm_pkg::IDX_SIZE);
    wire wrDiv = wrEn && (addrQ == linrm_pkg::IDX_DIV);
    wire wrMul = wrEn && (addrQ == linrm_pkg::IDX_MUL);
    wire wrId = wrEn && (addrQ == linrm_pkg::IDX_ID);
    wire wrMask = wrEn && (addrQ == linrm_pkg::IDX_IRQ_MSK);
    wire wrMode = wrEn && (addrQ == linrm_pkg::IDX_MODE);
    wire rdIrqSt = rdAcc && hit && (idx == linrm_pkg::IDX_IRQ_ST);

    // A write holds hreadyout low one cycle so a following read sees it
    always_ff @(posedge clk) begin
        if (rst) begin
            addrQ <= '0;
            wrHitQ <= 1'b0;
            wrPendQ <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= '0;
        end else begin
            wrPendQ <= accept && hwrite;
            hreadyout <= !(accept && hwrite);
            if (accept) begin
                addrQ <= idx;
                wrHitQ <= hwrite && hit;
            end
            if (rdAcc) begin
                hrdata <= {24'h000000, rdByte};
            end
        end
    end

    // Pin synchroniser for the monitored bus level
    logic rxMetaQ;
    logic rxSyncQ;
    always_ff @(posedge clk) begin
        if (rst) begin
            rxMetaQ <= 1'b1;
            rxSyncQ <= 1'b1;
        end else begin
            rxMetaQ <= linRxPin;
            rxSyncQ <= rxMetaQ;
        end
    end

    // Control and configuration
    logic [7:0] sizeQ;
    logic [7:0] mulQ;
    logic errorQ;
    wire ctrlStart = wrCtrl && wData[linrm_pkg::CTRL_START];
    wire ctrlWake = wrCtrl && wData[linrm_pkg::CTRL_WAKE];
    wire ctrlClrErr = wrCtrl && wData[linrm_pkg::CTRL_CLRERR];
    wire ctrlClrInt = wrCtrl && wData[linrm_pkg::CTRL_CLRINT];
    wire slaveWr = wrCtrl && !masterMode;

    always_ff @(posedge clk) begin
        if (rst) begin
            masterMode <= 1'b0;
            stopReq <= 1'b0;
            sleepMode <= 1'b0;
            directionSelect <= 1'b0;
            dataAck <= 1'b0;
            startRequest <= 1'b0;
            wakeupRequest <= 1'b0;
            sizeQ <= linrm_pkg::RST_BYTE;
            dividerLow <= linrm_pkg::RST_BYTE;
            mulQ <= linrm_pkg::RST_BYTE;
            frameIdentifier <= '0;
        end else begin
            if (wrMode) begin
                masterMode <= wData[linrm_pkg::MODE_MASTER];
            end
            if (wrCtrl) begin
                directionSelect <= wData[linrm_pkg::CTRL_DIR];
            end
            // Acknowledge and stop are per frame, so a new header drops them
            if (frameStart) begin
                stopReq <= 1'b0;
                dataAck <= 1'b0;
            end else if (slaveWr) begin
                stopReq <= wData[linrm_pkg::CTRL_STOP];
                dataAck <= wData[linrm_pkg::CTRL_DATA_ACKNOWLEDGE];
            end
            if (slaveWr) begin
                sleepMode <= wData[linrm_pkg::CTRL_SLEEP];
            end
            startRequest <= ctrlStart && masterMode && !errorQ;
            wakeupRequest <= ctrlWake && !errorQ;
            if (wrSize) begin
                sizeQ <= wData;
            end
            if (wrDiv) begin
                dividerLow <= wData;
            end
            if (wrMul) begin
                mulQ <= wData;
            end
            if (wrId) begin
                frameIdentifier <= wData[5:0];
            end
        end
    end

    assign enhancedChecksum = sizeQ[linrm_pkg::SIZE_ENH];
    assign frameLength = sizeQ[3:0];
    assign baudMultiplier = mulQ;

    // Data buffer; a byte from the bus engine wins over a software write
    genvar g;
    generate
        for (g = 0; g < linrm_pkg::NUM_DATA; g++) begin : gData
            wire engWr = rxByteValid && (rxByteIdx == 3'(g));
            wire swWr = wrEn && (addrQ == linrm_pkg::IDX_DATA0 + 5'(g));
            always_ff @(posedge clk) begin
                if (rst) begin
                    dataBuf[8*g +: 8] <= linrm_pkg::RST_BYTE;
                end else if (engWr) begin
                    dataBuf[8*g +: 8] <= rxByte;
                end else if (swWr) begin
                    dataBuf[8*g +: 8] <= wData;
                end
            end
        end
    endgenerate

    // Checksum: classic sums data only, enhanced starts from the identifier
    logic [7:0] sumQ;
    always_ff @(posedge clk) begin
        if (rst) begin
            sumQ <= '0;
        end else if (frameStart) begin
            sumQ <= '0;
        end else if (idValid && enhancedChecksum) begin
            sumQ <= idByte;
        end else if (rxByteValid) begin
            sumQ <= addCarry(sumQ, rxByte);
        end
    end

    // Protected identifier parity bits
    wire par0 = idByte[0] ^ idByte[1] ^ idByte[2] ^ idByte[4];
    wire par1 = !(idByte[1] ^ idByte[3] ^ idByte[4] ^ idByte[5]);
    wire parBad = (idByte[6] != par0) || (idByte[7] != par1);

    logic frameTooLong;
    linrm_frame_timer #(
        .LIMIT(FRAME_MAX_CYC)
    ) uTimer (
        .clk(clk),
        .rst(rst),
        .start(frameStart),
        .stop(frameEnd || frameAbort),
        .expired(frameTooLong)
    );

    // Error event detection
    wire syncEv = syncTolFail && !masterMode;
    wire parEv = idValid && parBad && !masterMode;
    wire toMaster = masterNoRespEv && masterMode;
    wire toSlave = slaveNoDataEv && !masterMode;
    wire noAck = rxByteValid && (rxByteIdx == 3'h0) && !masterMode
        && !dataAck && !stopReq;
    wire toutEv = toMaster || toSlave || frameTooLong || noAck;
    wire chkEv = chkValid && (addCarry(sumQ, chkByte) != linrm_pkg::CHK_GOOD);
    wire bitEv = bitSample && txActive && (rxSyncQ != txBit);
    logic [linrm_pkg::ERR_W-1:0] errSet;
    assign errSet = {syncEv, parEv, toutEv, chkEv, bitEv};
    wire anyErr = |errSet;

    // Error flags: a new error in the clearing cycle is kept
    logic [linrm_pkg::ERR_W-1:0] errQ;
    always_ff @(posedge clk) begin
        if (rst) begin
            errQ <= '0;
            errorQ <= 1'b0;
            frameAbort <= 1'b0;
        end else begin
            errQ <= (ctrlClrErr ? '0 : errQ) | errSet;
            errorQ <= (errorQ && !ctrlClrErr) || anyErr;
            frameAbort <= anyErr;
        end
    end

    // Sticky status bits, cleared by the clear-interrupt command
    logic idleQ;
    logic abortQ;
    logic wakeQ;
    logic doneQ;
    always_ff @(posedge clk) begin
        if (rst) begin
            idleQ <= 1'b0;
            abortQ <= 1'b0;
            wakeQ <= 1'b0;
            doneQ <= 1'b0;
        end else begin
            idleQ <= (idleQ && !ctrlClrInt) || idleTimeoutEv;
            abortQ <= (abortQ && !ctrlClrInt) || (anyErr && !masterMode);
            wakeQ <= (wakeQ && !ctrlClrInt) || wakeupEv;
            doneQ <= (doneQ && !ctrlClrInt) || doneEv;
        end
    end

    // Interrupt status: read clears, set wins, mask gates the output
    logic [linrm_pkg::IRQ_W-1:0] irqStQ;
    logic [linrm_pkg::IRQ_W-1:0] irqMaskQ;
    logic [linrm_pkg::IRQ_W-1:0] irqSet;
    assign irqSet = {idleTimeoutEv, wakeupEv, doneEv, anyErr};
    wire irqClr = rdIrqSt || ctrlClrInt;
    always_ff @(posedge clk) begin
        if (rst) begin
            irqStQ <= '0;
            irqMaskQ <= '0;
            irq <= 1'b0;
        end else begin
            irqStQ <= (irqClr ? '0 : irqStQ) | irqSet;
            if (wrMask) begin
                irqMaskQ <= wData[linrm_pkg::IRQ_W-1:0];
            end
            irq <= |(irqStQ & irqMaskQ);
        end
    end

    // Register views; command bits and unused bits read zero
    logic [7:0] ctrlView;
    logic [7:0] statView;
    logic [7:0] regView [0:linrm_pkg::NUM_REGS-1];
    assign ctrlView = {stopReq && !masterMode, sleepMode && !masterMode,
        directionSelect, dataAck && !masterMode, 4'h0};
    assign statView = {busActive, idleQ, abortQ && !masterMode,
        dataReqLvl && !masterMode, irq, errorQ, wakeQ, doneQ};
    generate
        for (g = 0; g < linrm_pkg::NUM_DATA; g++) begin : gView
            assign regView[g] = dataBuf[8*g +: 8];
        end
    endgenerate
    assign regView[linrm_pkg::IDX_CTRL] = ctrlView;
    assign regView[linrm_pkg::IDX_STAT] = statView;
    assign regView[linrm_pkg::IDX_ERR] = {3'h0, errQ};
    assign regView[linrm_pkg::IDX_SIZE] = {sizeQ[7], 3'h0, sizeQ[3:0]};
    assign regView[linrm_pkg::IDX_DIV] = dividerLow;
    assign regView[linrm_pkg::IDX_MUL] = mulQ;
    assign regView[linrm_pkg::IDX_ID] = {2'h0, frameIdentifier};
    assign regView[linrm_pkg::IDX_IRQ_ST] = {4'h0, irqStQ};
    assign regView[linrm_pkg::IDX_IRQ_MSK] = {4'h0, irqMaskQ};
    assign regView[linrm_pkg::IDX_MODE] = {7'h00, masterMode};
    assign rdByte = hit ? regView[idx] : 8'h00;
endmodule

// ### pkg/linrm_pkg.sv
/*
 Constants of the link register map and error detection block:
 register indices, field positions, reset values and timing.
 Assumes a 125 MHz system clock.
*/
package linrm_pkg;
    localparam int IDX_W = 5;
    localparam logic [4:0] IDX_DATA0 = 5'h00;
    localparam logic [4:0] IDX_CTRL = 5'h08;
    localparam logic [4:0] IDX_STAT = 5'h09;
    localparam logic [4:0] IDX_ERR = 5'h0a;
    localparam logic [4:0] IDX_SIZE = 5'h0b;
    localparam logic [4:0] IDX_DIV = 5'h0c;
    localparam logic [4:0] IDX_MUL = 5'h0d;
    localparam logic [4:0] IDX_ID = 5'h0e;
    localparam logic [4:0] IDX_IRQ_ST = 5'h0f;
    localparam logic [4:0] IDX_IRQ_MSK = 5'h10;
    localparam logic [4:0] IDX_MODE = 5'h11;
    localparam int NUM_REGS = 18;
    localparam int NUM_DATA = 8;
    localparam int CTRL_STOP = 7;
    localparam int CTRL_SLEEP = 6;
    localparam int CTRL_DIR = 5;
    localparam int CTRL_DATA_ACKNOWLEDGE = 4;
    localparam int CTRL_CLRINT = 3;
    localparam int CTRL_CLRERR = 2;
    localparam int CTRL_WAKE = 1;
    localparam int CTRL_START = 0;
    localparam int ST_ACTIVE = 7;
    localparam int ST_IDLE = 6;
    localparam int ST_ABORT = 5;
    localparam int ST_DREQ = 4;
    localparam int ST_PEND = 3;
    localparam int ST_ERROR = 2;
    localparam int ST_WAKEUP = 1;
    localparam int ST_DONE = 0;
    localparam int ERR_SYNC = 4;
    localparam int ERR_PAR = 3;
    localparam int ERR_TIMEOUT_ERROR = 2;
    localparam int ERR_CHK = 1;
    localparam int ERR_BIT = 0;
    localparam int ERR_W = 5;
    localparam int IRQ_ERR = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_IDLE = 3;
    localparam int IRQ_W = 4;
    localparam int SIZE_ENH = 7;
    localparam int MODE_MASTER = 0;
    localparam int ID_W = 6;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CHK_GOOD = 8'hff;
    localparam int CLK_NS = 8;
    localparam int FRAME_MAX_US = 10000;
endpackage

// ### logic/linrm_frame_timer.sv
/*
 Frame length watchdog: counts cycles from frame start to frame end.
 Assumes start, stop and abort are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module linrm_frame_timer #(
    parameter int LIMIT = 1250000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic stop,
    output logic expired
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    logic [CW-1:0] countQ;
    logic runQ;
    wire atLimit = runQ && (countQ == LAST);

    always_ff @(posedge clk) begin
        if (rst) begin
            countQ <= '0;
            runQ <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= atLimit && !stop && !start;
            if (start) begin
                countQ <= '0;
                runQ <= 1'b1;
            end else if (stop || atLimit) begin
                runQ <= 1'b0;
            end else if (runQ) begin
                countQ <= countQ + 1'b1;
            end
        end
    end
endmodule

// ### verification/linrm_bus_model.sv
/*
 Model of the shared link wire as the transceiver returns it.
 Assumes the engine drives txBit while txActive; corrupt flips the echo.
*/
`timescale 1ns/1ps
module linrm_bus_model (
    input wire logic txActive,
    input wire logic txBit,
    input wire logic corrupt,
    output logic linRxPin
);
    // Released wire sits at the recessive pull-up level
    assign linRxPin = txActive ? (txBit ^ corrupt) : 1'b1;
endmodule

// ### verification/linrm_core_chk.sv
/*
 Concurrent checks on the ports of linrm_core.
 Assumes one clock with synchronous active high reset; bound below.
*/
`timescale 1ns/1ps
module linrm_core_chk #(
    parameter int FRAME_MAX_US = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic linRxPin,
    input wire logic idValid,
    input wire logic [7:0] idByte,
    input wire logic rxByteValid,
    input wire logic [2:0] rxByteIdx,
    input wire logic syncTolFail,
    input wire logic masterNoRespEv,
    input wire logic slaveNoDataEv,
    input wire logic txActive,
    input wire logic txBit,
    input wire logic bitSample,
    input wire logic masterMode,
    input wire logic stopReq,
    input wire logic dataAck,
    input wire logic startRequest,
    input wire logic frameAbort
);
    wire rdTake = hsel && htrans[1] && hready && !hwrite;
    wire parBad = (idByte[6] != ^{idByte[0], idByte[1], idByte[2], idByte[4]}) ||
        (idByte[7] != ~^{idByte[1], idByte[3], idByte[4], idByte[5]});
    wire mism = linRxPin != txBit;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rdzero; rdTake && haddr == 32'h28 |=> hrdata[31:5] == 27'h0; endproperty
    a_rdzero: assert property (p_rdzero) else $error("error register high bits set");
    property p_sync; syncTolFail && !masterMode |-> ##[1:3] frameAbort; endproperty
    a_sync: assert property (p_sync) else $error("sync error not acted on");
    property p_par; idValid && !masterMode && parBad |-> ##[1:3] frameAbort; endproperty
    a_par: assert property (p_par) else $error("parity error not acted on");
    property p_mnr; masterNoRespEv && masterMode |-> ##[1:3] frameAbort; endproperty
    a_mnr: assert property (p_mnr) else $error("missing response not acted on");
    property p_snd; slaveNoDataEv && !masterMode |-> ##[1:3] frameAbort; endproperty
    a_snd: assert property (p_snd) else $error("missing data not acted on");
    property p_ack;
        rxByteValid && rxByteIdx == 3'h0 && !masterMode && !dataAck && !stopReq
            |-> ##[1:3] frameAbort;
    endproperty
    a_ack: assert property (p_ack) else $error("missing acknowledge not acted on");
    property p_bit;
        txActive && bitSample && mism && $past(mism) && $past(mism, 2) && $past(mism, 3)
            |-> ##[1:3] frameAbort;
    endproperty
    a_bit: assert property (p_bit) else $error("bit mismatch not acted on");
    property p_start; startRequest |-> masterMode; endproperty
    a_start: assert property (p_start) else $error("start request in slave mode");
    property p_stop; $rose(stopReq) || $rose(dataAck) |-> !masterMode; endproperty
    a_stop: assert property (p_stop) else $error("slave bit set in master mode");
endmodule
bind linrm_core linrm_core_chk #(.FRAME_MAX_US(FRAME_MAX_US)) u_chk (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .linRxPin(linRxPin), .idValid(idValid), .idByte(idByte),
    .rxByteValid(rxByteValid), .rxByteIdx(rxByteIdx), .syncTolFail(syncTolFail),
    .masterNoRespEv(masterNoRespEv), .slaveNoDataEv(slaveNoDataEv), .txActive(txActive),
    .txBit(txBit), .bitSample(bitSample), .masterMode(masterMode), .stopReq(stopReq),
    .dataAck(dataAck), .startRequest(startRequest), .frameAbort(frameAbort));

// ### verification/tb_linrm_core.sv
/*
 Testbench of linrm_core: AHB-Lite register tasks and engine event pulses.
 Assumes this bench plays the frame engine; the wire model echoes txBit.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("unexpected %s expected %h seen %h", nm, e, g); n_errors++; end end
module tb_linrm_core;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, corrupt = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, rxByteIdx = 3'h0;
    logic hreadyout, hresp, linRxPin, masterMode, frameAbort, irq, startRequest;
    logic wakeupRequest, stopReq, dataAck, sleepMode, directionSelect, enhancedChecksum;
    logic [3:0] frameLength;
    logic [7:0] dividerLow, baudMultiplier;
    logic [5:0] frameIdentifier;
    logic frameStart = 1'b0, frameEnd = 1'b0, idValid = 1'b0, rxByteValid = 1'b0;
    logic chkValid = 1'b0, syncTolFail = 1'b0, masterNoRespEv = 1'b0, slaveNoDataEv = 1'b0;
    logic txActive = 1'b0, txBit = 1'b1, bitSample = 1'b0, doneEv = 1'b0;
    logic [7:0] idByte = 8'h0, rxByte = 8'h0, chkByte = 8'h0;
    logic [63:0] dataBuf;
    int n_errors = 0, n_tests = 0, cycles = 0, nAbort = 0, nStart = 0, nWake = 0;
    int evK[12] = '{0, 0, 1, 1, 9, 2, 3, 4, 5, 8, 6, 7};
    logic evM[12] = '{0, 1, 0, 1, 0, 1, 0, 0, 0, 0, 0, 1};
    logic [7:0] evE[12] = '{8'h10, 8'h00, 8'h08, 8'h00, 8'h00, 8'h04, 8'h04, 8'h02,
        8'h01, 8'h00, 8'h04, 8'h04};
    linrm_core #(.FRAME_MAX_US(1)) u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .linRxPin(linRxPin),
        .frameStart(frameStart), .frameEnd(frameEnd), .idValid(idValid), .idByte(idByte),
        .rxByteValid(rxByteValid), .rxByteIdx(rxByteIdx), .rxByte(rxByte),
        .chkValid(chkValid), .chkByte(chkByte), .syncTolFail(syncTolFail),
        .masterNoRespEv(masterNoRespEv), .slaveNoDataEv(slaveNoDataEv), .txActive(txActive),
        .txBit(txBit), .bitSample(bitSample), .busActive(1'b0), .dataReqLvl(1'b0),
        .idleTimeoutEv(1'b0), .wakeupEv(1'b0), .doneEv(doneEv), .dataBuf(dataBuf),
        .masterMode(masterMode), .stopReq(stopReq), .sleepMode(sleepMode),
        .directionSelect(directionSelect),
        .dataAck(dataAck), .startRequest(startRequest), .wakeupRequest(wakeupRequest),
        .frameAbort(frameAbort), .enhancedChecksum(enhancedChecksum),
        .frameLength(frameLength), .dividerLow(dividerLow), .baudMultiplier(baudMultiplier),
        .frameIdentifier(frameIdentifier), .irq(irq));
    linrm_bus_model u_bus (.txActive(txActive), .txBit(txBit), .corrupt(corrupt),
        .linRxPin(linRxPin));
    always #4 clk = ~clk;
    task automatic end_of_test();
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        nAbort += (frameAbort === 1'b1);
        nStart += (startRequest === 1'b1);
        nWake += (wakeupRequest === 1'b1);
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {25'h0, idx, 2'h0}; hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, wd};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask
    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask
    task automatic rdc(input logic [4:0] idx, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, idx, 8'h0, x);
        `CHK("register", e, x)
    endtask
    // Code 0 done, 1 frame start, 2 frame end; one cycle high
    task automatic pulse(input int w);
        @(posedge clk);
        if (w == 0) begin
            doneEv <= 1'b1;
        end else if (w == 1) begin
            frameStart <= 1'b1;
        end else begin
            frameEnd <= 1'b1;
        end
        @(posedge clk);
        {doneEv, frameStart, frameEnd} <= 3'h0;
    endtask
    // Each code but 7 plays one engine report, 7 outlasts the frame timer; the wire is held four cycles for the synchroniser
    task automatic ev(input int k);
        @(posedge clk);
        case (k)
            0: syncTolFail <= 1'b1;
            1, 9: begin idValid <= 1'b1; idByte <= (k == 1) ? 8'h00 : 8'h80; end
            2: masterNoRespEv <= 1'b1;
            3: slaveNoDataEv <= 1'b1;
            4: begin chkValid <= 1'b1; chkByte <= 8'h00; end
            5, 8: begin
                corrupt <= (k == 5); txActive <= 1'b1; txBit <= 1'b0;
                repeat (4) @(posedge clk);
                bitSample <= 1'b1;
            end
            6: begin rxByteValid <= 1'b1; rxByteIdx <= 3'h0; rxByte <= 8'h5a; end
            default: repeat (140) @(posedge clk);
        endcase
        @(posedge clk);
        {syncTolFail, idValid, masterNoRespEv, slaveNoDataEv, chkValid} <= 5'h0;
        {bitSample, rxByteValid, txActive, txBit, corrupt} <= 5'h02;
    endtask
    initial begin
        int a, s, w;
        logic [7:0] x;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 15; i++) rdc(5'(i), 8'h00);
        wr(linrm_pkg::IDX_MODE, 8'h01);
        wr(linrm_pkg::IDX_CTRL, 8'h90);
        rdc(linrm_pkg::IDX_CTRL, 8'h00);
        wr(linrm_pkg::IDX_MODE, 8'h00);
        wr(linrm_pkg::IDX_CTRL, 8'h91);
        rdc(linrm_pkg::IDX_CTRL, 8'h90);
        wr(linrm_pkg::IDX_IRQ_MSK, 8'h01);
        pulse(0);
        repeat (4) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        wr(linrm_pkg::IDX_IRQ_MSK, 8'h03);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        rdc(linrm_pkg::IDX_IRQ_ST, 8'h02);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        for (int i = 0; i < 12; i++) begin
            a = nAbort; s = nStart; w = nWake;
            wr(linrm_pkg::IDX_MODE, {7'h0, evM[i]});
            pulse(1);
            ev(evK[i]);
            repeat (4) @(posedge clk);
            rdc(linrm_pkg::IDX_ERR, evE[i]);
            `CHK("abort", evE[i] != 8'h0, nAbort != a)
            `CHK("irq", evE[i] != 8'h0, irq)
            bus(1'b0, linrm_pkg::IDX_STAT, 8'h0, x);
            `CHK("summary", evE[i] != 8'h0, x[linrm_pkg::ST_ERROR])
            wr(linrm_pkg::IDX_CTRL, 8'h03);
            // The pulse counters update at the edge the task returns on
            @(posedge clk);
            `CHK("start", evE[i] == 8'h0 && evM[i], nStart != s)
            `CHK("wake", evE[i] == 8'h0, nWake != w)
            wr(linrm_pkg::IDX_CTRL, 8'h0c);
            pulse(2);
            rdc(linrm_pkg::IDX_ERR, 8'h00);
            bus(1'b0, linrm_pkg::IDX_STAT, 8'h0, x);
            `CHK("summary", 1'b0, x[linrm_pkg::ST_ERROR])
        end
        for (int i = 0; i < 8; i++) wr(5'(i), 8'(17 * (i + 1)));
        for (int i = 0; i < 8; i++) rdc(5'(i), 8'(17 * (i + 1)));
        `CHK("dataBuf", 64'h8877665544332211, dataBuf)
        wr(linrm_pkg::IDX_ERR, 8'hff);
        rdc(linrm_pkg::IDX_ERR, 8'h00);
        wr(5'h12, 8'hff);
        rdc(5'h12, 8'h00);
        wr(linrm_pkg::IDX_DIV, 8'h5a);
        rdc(linrm_pkg::IDX_DIV, 8'h5a);
        `CHK("dividerLow", 8'h5a, dividerLow)
        wr(linrm_pkg::IDX_ID, 8'hff);
        rdc(linrm_pkg::IDX_ID, 8'h3f);
        `CHK("frameIdentifier", 6'h3f, frameIdentifier)
        wr(linrm_pkg::IDX_SIZE, 8'hff);
        rdc(linrm_pkg::IDX_SIZE, 8'h8f);
        `CHK("enhancedChecksum", 1'b1, enhancedChecksum)
        `CHK("frameLength", 4'hf, frameLength)
        wr(linrm_pkg::IDX_MUL, 8'ha5);
        rdc(linrm_pkg::IDX_MUL, 8'ha5);
        `CHK("baudMultiplier", 8'ha5, baudMultiplier)
        // Master mode is still selected here, so only direction may change
        wr(linrm_pkg::IDX_CTRL, 8'h60);
        `CHK("directionSelect", 1'b1, directionSelect)
        `CHK("sleepMode", 1'b0, sleepMode)
        `CHK("hresp", 1'b0, hresp)
        end_of_test();
    end
endmodule
